// [inc/pcsf_defs.vh]
/*
 * Constants for the socket present-state and force-event register bank:
 * register offsets, field positions, reset values and field widths.
 * Assumes it is included by bare name from the design, assertion and bench files.
 */
`ifndef PCSF_DEFS_VH
`define PCSF_DEFS_VH

// Register byte offsets on the APB bus
`define PCSF_OFS_EVENT 8'h00
`define PCSF_OFS_MASK 8'h04
`define PCSF_OFS_STATE 8'h08
`define PCSF_OFS_FORCE 8'h0c
`define PCSF_ADDR_W 8

// Present-state field positions
`define PCSF_ST_SOCK_CAP_HI 31
`define PCSF_ST_SOCK_CAP_LO 28
`define PCSF_ST_VOLT_HI 13
`define PCSF_ST_VOLT_LO 10
`define PCSF_ST_INVALID_SUPPLY 9
`define PCSF_ST_REMOVAL_LOSS 8
`define PCSF_ST_UNRECOG 7
`define PCSF_ST_CARD_INT 6
`define PCSF_ST_BUS_CARD 5
`define PCSF_ST_NARROW_CARD 4
`define PCSF_ST_POWERED 3
`define PCSF_ST_DETECT2 2
`define PCSF_ST_DETECT1 1
`define PCSF_ST_STSCHG 0

// Force-event field positions
`define PCSF_FE_REINTERROGATE 14
`define PCSF_FE_VOLT_HI 13
`define PCSF_FE_VOLT_LO 10

// Event, status and mask field positions (same layout)
`define PCSF_EV_POWER 3
`define PCSF_EV_DETECT2 2
`define PCSF_EV_DETECT1 1
`define PCSF_EV_STSCHG 0
`define PCSF_EV_W 4

// Reset values
`define PCSF_RST_SOCK_CAP 4'h3
`define PCSF_RST_VOLT 4'h0
`define PCSF_RST_DETECT 1'h1
`define PCSF_RST_FLAG 1'h0
`define PCSF_RST_EVENTS 4'h0
`define PCSF_RST_MASK 4'h0
`define PCSF_RST_POWER_CTRL 1'h1
`define PCSF_RST_DATA 32'h0000_0000

`endif

// [hdl/pcsf_regs.v]
/*
 * Socket present-state and force-event register bank for one card socket,
 * with a small event/mask pair that drives one level interrupt.
 * Assumes an APB master on the host clock, card pins already synchronous
 * to REF_CLK_IN, and an external interrogation sequencer and power switch.
 */
// Added by the designer: register access over APB.
`include "pcsf_defs.vh"
`default_nettype none

// Behaviour
// RULE1 - Bit 9 flags a host request for socket power at an invalid supply.
// RULE2 - Bit 8 flags possible data loss at card removal.
// RULE3 - Bit 7 flags an unrecognizable card, held until a valid card arrives.
// RULE4 - Bit 6 follows the live card ready/interrupt pin level.
// RULE5 - Bits 5 and 4 give card type, updated only by interrogation. Code also loads them on force writes and clears them on context clear.
// RULE6 - Bit 3 shows socket power: 0 powered down (reset), 1 powered up.
// RULE7 - Bits 2 and 1 follow detect pins, frozen during interrogation.
// RULE8 - Bit 0 follows the live status-change pin level.
// RULE9 - Context bits clear on global reset; bus reset too when PME off.
// RULE10 - Force register bits 31 to 15 and bit 6 read zero.
// RULE11 - Force bit 14 re-interrogates, refreshes state, re-enables power.
// RULE12 - Software writes bit 14 when a forced change needs interrogation.
// RULE13 - Force bits 13 to 10 write voltage bits; any one disables power. Code keeps power enabled when bit 14 is written together with them.
// RULE14 - Force bits 9, 8, 7, 5, 4 write the same state bits.
// RULE15 - Force bit 3 writes the power event flag, not the power state.
// RULE16 - Force bits 2 and 1 write detect event flags, not detect levels.
// RULE17 - Force bit 0 writes the status-change event flag, not the level.
// RULE18 - Power event interrupts only when mask bit 3 is one.
// RULE19 - A forced zero leaves an event flag alone; only one sets it.
module pcsf_regs (
	input wire REF_CLK_IN,
	input wire RST_B_IN,
	input wire BUS_RST_B_IN,
	input wire PME_EN_IN,
	input wire PSEL_IN,
	input wire PENABLE_IN,
	input wire PWRITE_IN,
	input wire [`PCSF_ADDR_W-1:0] PADDR_IN,
	input wire [31:0] PWDATA_IN,
	output reg [31:0] PRDATA_OUT,
	output reg PREADY_OUT,
	output reg PSLVERR_OUT,
	input wire CARD_INT_PIN_IN,
	input wire DETECT1_PIN_IN,
	input wire DETECT2_PIN_IN,
	input wire STSCHG_PIN_IN,
	input wire POWER_GOOD_IN,
	input wire BAD_SUPPLY_REQ_IN,
	input wire REMOVAL_LOSS_IN,
	input wire INTERROG_BUSY_IN,
	input wire INTERROG_DONE_IN,
	input wire RES_BUS_CARD_IN,
	input wire RES_NARROW_CARD_IN,
	input wire RES_UNRECOG_IN,
	input wire [3:0] RES_VOLT_CAP_IN,
	output reg REINTERROGATE_OUT,
	output reg POWER_CTRL_EN_OUT,
	output reg IRQ_OUT
);

////////////////////////////////////////////////////////////////////////////////
// State

reg [3:0] volt_capable;
reg invalid_supply_request;
reg removal_loss_flag;
reg unrecognized_card_flag;
reg card_int_level;
reg bus_card_detected;
reg narrow_card_detected;
reg socket_powered;
reg detect_pin2_level;
reg detect_pin1_level;
reg status_change_level;
reg [`PCSF_EV_W-1:0] event_flags;
reg [`PCSF_EV_W-1:0] event_mask;
reg [`PCSF_EV_W-1:0] read_clear;

////////////////////////////////////////////////////////////////////////////////
// Bus decode

wire setup_phase;
wire write_strobe;
wire read_strobe;
wire sel_event;
wire sel_mask;
wire sel_state;
wire sel_force;
wire mapped;
wire force_write;
wire ctx_clear;
wire refresh;

// Setup cycle: read data and the answer are prepared here
assign setup_phase = PSEL_IN & ~PENABLE_IN;
// Access completes on the edge where pready is seen high
assign write_strobe = PSEL_IN & PENABLE_IN & PREADY_OUT & PWRITE_IN;
assign read_strobe = PSEL_IN & PENABLE_IN & PREADY_OUT & ~PWRITE_IN;
assign sel_event = (PADDR_IN == `PCSF_OFS_EVENT);
assign sel_mask = (PADDR_IN == `PCSF_OFS_MASK);
assign sel_state = (PADDR_IN == `PCSF_OFS_STATE);
assign sel_force = (PADDR_IN == `PCSF_OFS_FORCE);
assign mapped = sel_event | sel_mask | sel_state | sel_force;
assign force_write = write_strobe & sel_force;

// Bus reset clears context bits only while PME is off
assign ctx_clear = ~BUS_RST_B_IN & ~PME_EN_IN; // RULE9

// Interrogation result from the sequencer refreshes card-type state
assign refresh = INTERROG_DONE_IN; // RULE5

////////////////////////////////////////////////////////////////////////////////
// Read data assembly

reg [31:0] state_word;
reg [31:0] next_rdata;

// Present-state word as software sees it
always @* begin
	state_word = `PCSF_RST_DATA;
	state_word[`PCSF_ST_SOCK_CAP_HI:`PCSF_ST_SOCK_CAP_LO] = `PCSF_RST_SOCK_CAP;
	state_word[`PCSF_ST_VOLT_HI:`PCSF_ST_VOLT_LO] = volt_capable;
	state_word[`PCSF_ST_INVALID_SUPPLY] = invalid_supply_request;
	state_word[`PCSF_ST_REMOVAL_LOSS] = removal_loss_flag;
	state_word[`PCSF_ST_UNRECOG] = unrecognized_card_flag;
	state_word[`PCSF_ST_CARD_INT] = card_int_level;
	state_word[`PCSF_ST_BUS_CARD] = bus_card_detected;
	state_word[`PCSF_ST_NARROW_CARD] = narrow_card_detected;
	state_word[`PCSF_ST_POWERED] = socket_powered;
	state_word[`PCSF_ST_DETECT2] = detect_pin2_level;
	state_word[`PCSF_ST_DETECT1] = detect_pin1_level;
	state_word[`PCSF_ST_STSCHG] = status_change_level;
end

// Read mux; the force register is write-only and reads all zero
always @* begin
	next_rdata = `PCSF_RST_DATA;
	if (sel_event) begin
		next_rdata[`PCSF_EV_W-1:0] = event_flags;
	end else if (sel_mask) begin
		next_rdata[`PCSF_EV_W-1:0] = event_mask;
	end else if (sel_state) begin
		next_rdata = state_word;
	end else begin
		next_rdata = `PCSF_RST_DATA; // RULE10
	end
end

////////////////////////////////////////////////////////////////////////////////
// APB answer: one wait-free access phase after each setup cycle

always @(posedge REF_CLK_IN or negedge RST_B_IN) begin
	if (!RST_B_IN) begin
		PRDATA_OUT <= `PCSF_RST_DATA;
		PREADY_OUT <= 1'b0;
		PSLVERR_OUT <= 1'b0;
		read_clear <= `PCSF_RST_EVENTS;
	end else begin
		PREADY_OUT <= setup_phase;
		PSLVERR_OUT <= setup_phase & ~mapped;
		if (setup_phase) begin
			PRDATA_OUT <= PWRITE_IN ? `PCSF_RST_DATA : next_rdata;
			// Only bits actually returned are cleared by this read
			read_clear <= (sel_event & ~PWRITE_IN) ? event_flags :
				`PCSF_RST_EVENTS;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Live pin levels

// Pins are sampled each cycle; detect levels freeze during interrogation
always @(posedge REF_CLK_IN or negedge RST_B_IN) begin
	if (!RST_B_IN) begin
		card_int_level <= 1'b0;
		status_change_level <= 1'b0;
		detect_pin2_level <= `PCSF_RST_DETECT;
		detect_pin1_level <= `PCSF_RST_DETECT;
		socket_powered <= 1'b0;
	end else begin
		card_int_level <= CARD_INT_PIN_IN; // RULE4
		status_change_level <= STSCHG_PIN_IN; // RULE8
		if (!INTERROG_BUSY_IN) begin
			detect_pin2_level <= DETECT2_PIN_IN; // RULE7
			detect_pin1_level <= DETECT1_PIN_IN; // RULE7
		end
		if (ctx_clear) begin
			socket_powered <= 1'b0; // RULE9
		end else begin
			// Force bit 3 never touches this level
			socket_powered <= POWER_GOOD_IN; // RULE6 RULE15
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Card-type, voltage and error flags

always @(posedge REF_CLK_IN or negedge RST_B_IN) begin
	if (!RST_B_IN) begin
		volt_capable <= `PCSF_RST_VOLT;
		invalid_supply_request <= `PCSF_RST_FLAG;
		removal_loss_flag <= `PCSF_RST_FLAG;
		unrecognized_card_flag <= `PCSF_RST_FLAG;
		bus_card_detected <= `PCSF_RST_FLAG;
		narrow_card_detected <= `PCSF_RST_FLAG;
	end else if (ctx_clear) begin
		volt_capable <= `PCSF_RST_VOLT; // RULE9
		invalid_supply_request <= `PCSF_RST_FLAG;
		removal_loss_flag <= `PCSF_RST_FLAG;
		unrecognized_card_flag <= `PCSF_RST_FLAG;
		bus_card_detected <= `PCSF_RST_FLAG;
		narrow_card_detected <= `PCSF_RST_FLAG;
	end else if (force_write) begin
		// Direct overwrite of the state bits by software
		volt_capable <=
			PWDATA_IN[`PCSF_FE_VOLT_HI:`PCSF_FE_VOLT_LO]; // RULE13
		invalid_supply_request <=
			PWDATA_IN[`PCSF_ST_INVALID_SUPPLY]; // RULE14
		removal_loss_flag <= PWDATA_IN[`PCSF_ST_REMOVAL_LOSS]; // RULE14
		unrecognized_card_flag <= PWDATA_IN[`PCSF_ST_UNRECOG]; // RULE14
		bus_card_detected <= PWDATA_IN[`PCSF_ST_BUS_CARD]; // RULE14
		narrow_card_detected <= PWDATA_IN[`PCSF_ST_NARROW_CARD]; // RULE14
	end else begin
		// A bad request or a lossy removal is sticky until rewritten
		if (BAD_SUPPLY_REQ_IN) begin
			invalid_supply_request <= 1'b1; // RULE1
		end
		if (REMOVAL_LOSS_IN) begin
			removal_loss_flag <= 1'b1; // RULE2
		end
		if (refresh) begin
			volt_capable <= RES_VOLT_CAP_IN; // RULE11
			bus_card_detected <= RES_BUS_CARD_IN; // RULE5
			narrow_card_detected <= RES_NARROW_CARD_IN; // RULE5
			// Set by a bad card, released only by a valid one
			if (RES_UNRECOG_IN) begin
				unrecognized_card_flag <= 1'b1; // RULE3
			end else if (RES_BUS_CARD_IN | RES_NARROW_CARD_IN) begin
				unrecognized_card_flag <= 1'b0; // RULE3
			end
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Re-interrogation request and socket power control

wire force_volt_any;
wire force_reinterrogate;

assign force_volt_any = |PWDATA_IN[`PCSF_FE_VOLT_HI:`PCSF_FE_VOLT_LO];
assign force_reinterrogate = PWDATA_IN[`PCSF_FE_REINTERROGATE];

// One-cycle request to the sequencer; power control gate follows forcing
always @(posedge REF_CLK_IN or negedge RST_B_IN) begin
	if (!RST_B_IN) begin
		REINTERROGATE_OUT <= 1'b0;
		POWER_CTRL_EN_OUT <= `PCSF_RST_POWER_CTRL;
	end else begin
		REINTERROGATE_OUT <= force_write & force_reinterrogate; // RULE11
		if (ctx_clear) begin
			POWER_CTRL_EN_OUT <= `PCSF_RST_POWER_CTRL; // RULE9
		end else if (force_write & force_reinterrogate) begin
			POWER_CTRL_EN_OUT <= 1'b1; // RULE11
		end else if (force_write & force_volt_any) begin
			POWER_CTRL_EN_OUT <= 1'b0; // RULE13
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Event sources: level changes on power state, detect pins, status pin

reg socket_powered_d;
reg detect_pin2_d;
reg detect_pin1_d;
reg status_change_d;
wire [`PCSF_EV_W-1:0] hw_event;

always @(posedge REF_CLK_IN or negedge RST_B_IN) begin
	if (!RST_B_IN) begin
		socket_powered_d <= 1'b0;
		detect_pin2_d <= `PCSF_RST_DETECT;
		detect_pin1_d <= `PCSF_RST_DETECT;
		status_change_d <= 1'b0;
	end else begin
		socket_powered_d <= socket_powered;
		detect_pin2_d <= detect_pin2_level;
		detect_pin1_d <= detect_pin1_level;
		status_change_d <= status_change_level;
	end
end

// Change on the stored power, detect or status level raises its event
assign hw_event[`PCSF_EV_POWER] = socket_powered ^ socket_powered_d;
assign hw_event[`PCSF_EV_DETECT2] = detect_pin2_level ^ detect_pin2_d;
assign hw_event[`PCSF_EV_DETECT1] = detect_pin1_level ^ detect_pin1_d;
assign hw_event[`PCSF_EV_STSCHG] = status_change_level ^ status_change_d;

////////////////////////////////////////////////////////////////////////////////
// Sticky event flags: set wins over the read clear

wire event_read_done;

assign event_read_done = read_strobe & sel_event;

genvar gi;
generate
	for (gi = 0; gi < `PCSF_EV_W; gi = gi + 1) begin : g_event
		wire forced_set;
		// Only a written one forces the flag
		assign forced_set = force_write & PWDATA_IN[gi]; // RULE19
		always @(posedge REF_CLK_IN or negedge RST_B_IN) begin
			if (!RST_B_IN) begin
				event_flags[gi] <= 1'b0;
			end else if (ctx_clear) begin
				event_flags[gi] <= 1'b0; // RULE9
			end else if (hw_event[gi] | forced_set) begin
				// Force bits 3..0 hit the flags, not the levels
				event_flags[gi] <= 1'b1; // RULE15 RULE16 RULE17
			end else if (event_read_done & read_clear[gi]) begin
				event_flags[gi] <= 1'b0;
			end
		end
	end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Mask register and interrupt output

always @(posedge REF_CLK_IN or negedge RST_B_IN) begin
	if (!RST_B_IN) begin
		event_mask <= `PCSF_RST_MASK;
	end else if (ctx_clear) begin
		event_mask <= `PCSF_RST_MASK; // RULE9
	end else if (write_strobe & sel_mask) begin
		event_mask <= PWDATA_IN[`PCSF_EV_W-1:0];
	end
end

// Level interrupt while any unmasked flag stands
always @(posedge REF_CLK_IN or negedge RST_B_IN) begin
	if (!RST_B_IN) begin
		IRQ_OUT <= 1'b0;
	end else begin
		IRQ_OUT <= |(event_flags & event_mask); // RULE18
	end
end

endmodule

`default_nettype wire

// [test/pcsf_card.sv]
/* Card and interrogation model for one socket.
   Assumes the bench sets the card's answer before asking for a test. */
`default_nettype none
module pcsf_card (
	input wire logic clk_in,
	input wire logic reint_in,
	input wire logic [6:0] res_in,
	output logic busy_out,
	output logic done_out,
	output logic [6:0] res_out
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt = 0;
	initial done_out = 1'b0;
	// Busy for 16 cycles per request, then a one-cycle result pulse
	always @(posedge clk_in) begin
		done_out <= 1'b0;
		if (reint_in)
			cnt <= 16;
		else if (cnt > 1)
			cnt <= cnt - 1;
		else if (cnt == 1) begin
			cnt <= 0;
			done_out <= 1'b1;
		end
	end
	// Results are only valid with the pulse; otherwise inverted junk
	assign busy_out = cnt != 0;
	assign res_out = done_out ? res_in : ~res_in;
endmodule
`default_nettype wire

// [test/pcsf_regs_sva.sv]
/* Port checks for the socket register bank.
   Assumes every setup cycle is followed by an access cycle. */
`include "pcsf_defs.vh"
`default_nettype none
module pcsf_regs_sva (
	input wire REF_CLK_IN,
	input wire RST_B_IN,
	input wire PSEL_IN,
	input wire PENABLE_IN,
	input wire PWRITE_IN,
	input wire [7:0] PADDR_IN,
	input wire [31:0] PWDATA_IN,
	input wire [31:0] PRDATA_OUT,
	input wire PREADY_OUT,
	input wire CARD_INT_PIN_IN,
	input wire STSCHG_PIN_IN,
	input wire REINTERROGATE_OUT,
	input wire POWER_CTRL_EN_OUT
);
	default clocking @(posedge REF_CLK_IN);
	endclocking
	default disable iff (!RST_B_IN);
	// Completed transfers
	wire acc = PSEL_IN && PENABLE_IN && PREADY_OUT;
	wire fw = acc && PWRITE_IN && PADDR_IN == `PCSF_OFS_FORCE;
	wire rs = acc && !PWRITE_IN && PADDR_IN == `PCSF_OFS_STATE;
	wire rf = acc && !PWRITE_IN && PADDR_IN == `PCSF_OFS_FORCE;
	chk_ready_after_setup: assert property (
		PSEL_IN && !PENABLE_IN |=> PREADY_OUT)
		else $error("ready missing after setup");
	chk_int_level_read: assert property (
		rs |-> PRDATA_OUT[6] == $past(CARD_INT_PIN_IN, 2))
		else $error("card interrupt level wrong");
	chk_sts_level_read: assert property (
		rs |-> PRDATA_OUT[0] == $past(STSCHG_PIN_IN, 2))
		else $error("status change level wrong");
	chk_force_reads_zero: assert property (
		rf |-> PRDATA_OUT == 32'h0)
		else $error("force register read not zero");
	chk_retest_pulse: assert property (
		fw && PWDATA_IN[14] |=> ##[0:1] REINTERROGATE_OUT)
		else $error("no re-interrogation pulse");
	chk_retest_single: assert property (
		REINTERROGATE_OUT |=> !REINTERROGATE_OUT)
		else $error("re-interrogation pulse too long");
	chk_power_on: assert property (
		fw && PWDATA_IN[14] |=> POWER_CTRL_EN_OUT)
		else $error("power control not re-enabled");
	chk_power_off: assert property (
		fw && !PWDATA_IN[14] && |PWDATA_IN[13:10] |=> !POWER_CTRL_EN_OUT)
		else $error("power control not disabled");
	cover property (fw && PWDATA_IN[14]);
	cover property (rs && PRDATA_OUT[6]);
	cover property (fw && |PWDATA_IN[13:10]);
endmodule
bind pcsf_regs pcsf_regs_sva u_sva (
	.REF_CLK_IN(REF_CLK_IN), .RST_B_IN(RST_B_IN),
	.PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN),
	.PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT),
	.PREADY_OUT(PREADY_OUT), .CARD_INT_PIN_IN(CARD_INT_PIN_IN),
	.STSCHG_PIN_IN(STSCHG_PIN_IN), .REINTERROGATE_OUT(REINTERROGATE_OUT),
	.POWER_CTRL_EN_OUT(POWER_CTRL_EN_OUT)
);
`default_nettype wire

// [test/tb.sv]
/* Self-checking bench for the socket register bank.
   Assumes the card model answers each re-interrogation request. */
`include "pcsf_defs.vh"
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] EV = `PCSF_OFS_EVENT, MK = `PCSF_OFS_MASK;
	localparam logic [7:0] ST = `PCSF_OFS_STATE, FE = `PCSF_OFS_FORCE;
	localparam logic [31:0] B = 32'h3000_0000, FB = 32'h0000_0310;
	logic clk = 0, rst_b = 0, bus_rst_b = 1, pme_en = 0, rerr;
	logic psel = 0, penable = 0, pwrite = 0;
	logic int_pin = 0, det1 = 1, det2 = 1, sts_pin = 0;
	logic pwr_good = 0, bad_req = 0, loss = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, rdata;
	logic [6:0] res_set = 0;
	logic [2:0] kind [3] = '{3'b100, 3'b000, 3'b001};
	logic [31:0] fw3 [3] = '{32'h4000, 32'h4080, 32'h4080};
	logic [31:0] ex3 [3] = '{32'h84, 32'h84, 32'h14};
	wire [31:0] prdata;
	wire [6:0] res;
	wire pready, pslverr, busy, done, reint, pwr_en, irq;
	int errors = 0, samples_checked = 0, cyc = 0;
	initial forever #10 clk = ~clk;
	pcsf_regs dut (
		.REF_CLK_IN(clk), .RST_B_IN(rst_b), .BUS_RST_B_IN(bus_rst_b),
		.PME_EN_IN(pme_en), .PSEL_IN(psel), .PENABLE_IN(penable),
		.PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
		.PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
		.CARD_INT_PIN_IN(int_pin), .DETECT1_PIN_IN(det1),
		.DETECT2_PIN_IN(det2), .STSCHG_PIN_IN(sts_pin),
		.POWER_GOOD_IN(pwr_good), .BAD_SUPPLY_REQ_IN(bad_req),
		.REMOVAL_LOSS_IN(loss), .INTERROG_BUSY_IN(busy),
		.INTERROG_DONE_IN(done), .RES_BUS_CARD_IN(res[1]),
		.RES_NARROW_CARD_IN(res[0]), .RES_UNRECOG_IN(res[2]),
		.RES_VOLT_CAP_IN(res[6:3]), .REINTERROGATE_OUT(reint),
		.POWER_CTRL_EN_OUT(pwr_en), .IRQ_OUT(irq)
	);
	pcsf_card u_card (
		.clk_in(clk), .reint_in(reint), .res_in(res_set),
		.busy_out(busy), .done_out(done), .res_out(res)
	);
	////////////////////////////////////////////////////////////////////
	// Compare and report
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// One APB transfer, held until ready is sampled high
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(rdata, e);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Cuts a hung run short
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			print_verdict();
		end
	end
	////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		tick(2);
		rd(ST, B | 32'h6);
		rd(MK, 32'h0);
		xfer(1'b0, 8'h40, 32'h0);
		chk(rerr, 1'b1);
		chk(rdata, 32'h0);
		xfer(1'b1, ST, 32'hffff_ffff);
		rd(ST, B | 32'h6);
		xfer(1'b1, FE, 32'h0000_3fb0);
		chk(pwr_en, 1'b0);
		rd(ST, B | 32'h3fb6);
		rd(FE, 32'h0);
		res_set <= {4'h5, 3'b010};
		xfer(1'b1, FE, 32'h4000);
		chk(pwr_en, 1'b1);
		det1 <= 1'b0;
		tick(2);
		rd(ST, B | 32'h6);
		tick(20);
		rd(ST, B | 32'h1424);
		foreach (kind[i]) begin
			res_set <= {4'h0, kind[i]};
			xfer(1'b1, FE, fw3[i]);
			tick(22);
			rd(ST, B | 32'h4 | ex3[i]);
		end
		int_pin <= 1'b1;
		sts_pin <= 1'b1;
		pwr_good <= 1'b1;
		tick(3);
		rd(ST, B | 32'h5d);
		bad_req <= 1'b1;
		loss <= 1'b1;
		tick(1);
		bad_req <= 1'b0;
		loss <= 1'b0;
		tick(3);
		rd(ST, B | 32'h35d);
		xfer(1'b0, EV, 32'h0);
		xfer(1'b1, FE, FB | 32'h1);
		xfer(1'b1, FE, FB | 32'h4);
		rd(EV, 32'h5);
		rd(ST, B | 32'h35d);
		rd(EV, 32'h0);
		xfer(1'b1, FE, FB | 32'ha);
		tick(3);
		chk(irq, 1'b0);
		xfer(1'b1, MK, 32'h8);
		tick(3);
		chk(irq, 1'b1);
		rd(EV, 32'ha);
		tick(3);
		chk(irq, 1'b0);
		pme_en <= 1'b1;
		bus_rst_b <= 1'b0;
		tick(2);
		bus_rst_b <= 1'b1;
		rd(ST, B | 32'h35d);
		rd(MK, 32'h8);
		pme_en <= 1'b0;
		pwr_good <= 1'b0;
		bus_rst_b <= 1'b0;
		tick(2);
		bus_rst_b <= 1'b1;
		tick(2);
		rd(ST, B | 32'h45);
		rd(MK, 32'h0);
		print_verdict();
	end
endmodule
`default_nettype wire
